// ### sio_regs.svh
// Overview of operation
// - One 8-bit shift register receives serial data and sends written data.
// - Clock source 11 osc, 10 osc half, 01 timer half, 00 external slave.
// - Timer source: shift clock toggles on each timer 1 underflow not closer than a 1 MHz half period to the last.
// - Timer shift clock never faster than 1 MHz; osc sources and external clock are not limited.
// - Reset selects slave mode with external shift clock.
// - Master drives its selected internal clock onto the clock pin.
// - Master stops after 8 clocks, clock pin held at idle level.
// - Slave ignores clock edges after 8 clocks of the current byte.
// - Ready output on pin 3 in slave mode; general I/O in master.
// - Transmit pin carries serial data only while output enable is 1.
// - Reset leaves all four shared pins as general-purpose I/O.
// - Build-time polarity choice covers shift clock and ready together.
// - Writing 1 to the trigger bit starts an 8-bit transfer.
// - Edge select 1 shifts on active edge, 0 on opposite edge.
// - Completion flag sets even when masked; interrupt only if enabled.
// - Ready rises on trigger, drops on first clock high or data access.
`ifndef SIO_REGS_SVH
`define SIO_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SIO_OFF_CTRL    8'h00
`define SIO_OFF_TRIG    8'h04
`define SIO_OFF_DATA    8'h08
`define SIO_OFF_STATUS  8'h0C
`define SIO_OFF_CLEAR   8'h10
`define SIO_OFF_IRQEN   8'h14
`define SIO_OFF_GPIO    8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SIO_CTRL_SRC_LO   0
`define SIO_CTRL_SRC_HI   1
`define SIO_CTRL_EDGE     2
`define SIO_CTRL_FUNC     3
`define SIO_CTRL_OUTEN    4
`define SIO_SRC_OSC       2'h3
`define SIO_SRC_OSC_HALF  2'h2
`define SIO_SRC_TIMER     2'h1
`define SIO_SRC_SLAVE     2'h0
`define SIO_SRC_RESET     2'h0
`define SIO_BITS_PER_BYTE 4'h8
`define SIO_LAST_BIT      4'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define SIO_CLK_KHZ       200000
`define SIO_SCLK_MAX_KHZ  1000
`define SIO_HALF_MIN \
  ((`SIO_CLK_KHZ + 2 * `SIO_SCLK_MAX_KHZ - 1) / (2 * `SIO_SCLK_MAX_KHZ))

`endif

// ### sio_pkg.sv
package sio_pkg;
  // Transfer engine states
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } xfer_state_t;
endpackage : sio_pkg

// ### sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Raw pin in, filtered level and edge pulses out
interface sync_if;
  logic raw;
  logic level;
  logic rise;
  logic fall;
  modport sync_side (input raw, output level, output rise, output fall);
  modport user_side (output raw, input level, input rise, input fall);
endinterface : sync_if
`default_nettype wire

// ### pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; level moves once stages two and three agree
module pin_sync
  import sio_pkg::*;
(
  input  wire logic     i_clock,
  input  wire logic     i_rst_n,
  sync_if.sync_side     port
);
  logic [2:0] stg_q;
  logic [2:0] stg_d;
  logic       lvl_q;
  logic       lvl_d;
  logic       rise_q;
  logic       rise_d;
  logic       fall_q;
  logic       fall_d;

  // Stage one is read only by stage two
  always_comb begin
    stg_d  = {stg_q[1:0], port.raw};
    lvl_d  = (stg_q[1] == stg_q[2]) ? stg_q[2] : lvl_q;
    rise_d = lvl_d & ~lvl_q;
    fall_d = ~lvl_d & lvl_q;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stg_q  <= 3'h0;
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      stg_q  <= stg_d;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign port.level = lvl_q;
  assign port.rise  = rise_q;
  assign port.fall  = fall_q;
endmodule : pin_sync
`default_nettype wire

// ### serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "sio_regs.svh"
module serial_port
  import sio_pkg::*;
#(
  parameter bit POSITIVE_POL = 1'b1
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  input  wire logic        i_osc_clock,
  input  wire logic        i_timer1_underflow,
  input  wire logic [3:0]  i_port_in,
  output var  logic [3:0]  o_port_out,
  output var  logic [3:0]  o_port_oe,
  output var  logic        o_irq
);
  // Pin 0 rx, 1 tx, 2 shift clock, 3 ready
  localparam logic INV = ~POSITIVE_POL;
  localparam logic [7:0] HALF_MIN = 8'(`SIO_HALF_MIN);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  sync_if u_if_sclk ();
  sync_if u_if_rx ();
  sync_if u_if_osc ();
  assign u_if_sclk.raw = i_port_in[2];
  assign u_if_rx.raw   = i_port_in[0];
  assign u_if_osc.raw  = i_osc_clock;
  pin_sync u_sync_sclk (.i_clock(i_clock), .i_rst_n(i_rst_n),
                        .port(u_if_sclk));
  pin_sync u_sync_rx   (.i_clock(i_clock), .i_rst_n(i_rst_n),
                        .port(u_if_rx));
  pin_sync u_sync_osc  (.i_clock(i_clock), .i_rst_n(i_rst_n),
                        .port(u_if_osc));

  // ----------------------------------------
  // State
  // ----------------------------------------
  xfer_state_t state_q, state_d;
  logic [1:0]  src_q, src_d;
  logic        edge_q, edge_d;
  logic        func_q, func_d;
  logic        outen_q, outen_d;
  logic [3:0]  gout_q, gout_d;
  logic [3:0]  gdir_q, gdir_d;
  logic        irqen_q, irqen_d;
  logic        flag_q, flag_d;
  logic [7:0]  sr_q, sr_d;
  logic        tx_q, tx_d;
  logic        sclk_q, sclk_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        ready_q, ready_d;
  logic [7:0]  gap_q, gap_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [3:0]  pout_q, pout_d;
  logic [3:0]  poe_q, poe_d;
  logic        irq_q, irq_d;

  logic        setup, acc, wr, mapped, master, tick, ok_gap;
  logic        ext_rise, ext_fall, rise_ev, fall_ev, done;
  logic        trig_wr, data_acc, clr_wr;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Answer prepared in setup, so access phase never waits
  assign setup    = i_psel & ~i_penable;
  assign acc      = i_psel & i_penable & pready_q;
  assign wr       = acc & i_pwrite;
  assign trig_wr  = wr && i_paddr == `SIO_OFF_TRIG && i_pwdata[0];
  assign data_acc = acc && i_paddr == `SIO_OFF_DATA;
  assign clr_wr   = wr && i_paddr == `SIO_OFF_CLEAR && i_pwdata[0];

  always_comb begin
    mapped = 1'b1;
    case (i_paddr)
      `SIO_OFF_CTRL:   prdata_d = {27'h0, outen_q, func_q, edge_q, src_q};
      `SIO_OFF_TRIG:   prdata_d = 32'h0;
      `SIO_OFF_DATA:   prdata_d = {24'h0, sr_q};
      `SIO_OFF_STATUS: prdata_d = {30'h0, state_q == ST_RUN, flag_q};
      `SIO_OFF_CLEAR:  prdata_d = 32'h0;
      `SIO_OFF_IRQEN:  prdata_d = {31'h0, irqen_q};
      `SIO_OFF_GPIO:   prdata_d = {24'h0, gdir_q, gout_q};
      default: begin
        prdata_d = 32'h0;
        mapped   = 1'b0;
      end
    endcase
    if (!setup) begin
      prdata_d = prdata_q;
      mapped   = ~pslverr_q;
    end
    pready_d  = setup ? 1'b1 : (acc ? 1'b0 : pready_q);
    pslverr_d = ~mapped;
  end

  // ----------------------------------------
  // Shift clock sources
  // ----------------------------------------
  // Timer ticks closer than the 1 MHz half period are dropped
  assign ok_gap = gap_q >= HALF_MIN;
  assign master = src_q != `SIO_SRC_SLAVE;
  always_comb begin
    case (src_q)
      `SIO_SRC_OSC:      tick = u_if_osc.rise | u_if_osc.fall;
      `SIO_SRC_OSC_HALF: tick = u_if_osc.rise;
      `SIO_SRC_TIMER:    tick = i_timer1_underflow & ok_gap;
      default:           tick = 1'b0;
    endcase
  end
  assign ext_rise = POSITIVE_POL ? u_if_sclk.rise : u_if_sclk.fall;
  assign ext_fall = POSITIVE_POL ? u_if_sclk.fall : u_if_sclk.rise;
  // Edges beyond the eighth never reach the engine once idle
  assign rise_ev = (state_q == ST_RUN) &
                   (master ? (tick & ~sclk_q) : ext_rise);
  assign fall_ev = (state_q == ST_RUN) &
                   (master ? (tick & sclk_q) : ext_fall);
  assign done    = fall_ev && cnt_q == `SIO_LAST_BIT;

  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    sr_d    = sr_q;
    tx_d    = tx_q;
    sclk_d  = sclk_q;
    cnt_d   = cnt_q;
    ready_d = ready_q;
    gap_d   = (src_q == `SIO_SRC_TIMER && tick) ? 8'h0 :
              (ok_gap ? gap_q : gap_q + 8'h1);
    case (state_q)
      ST_IDLE: begin
        if (data_acc && i_pwrite)
          sr_d = i_pwdata[7:0];
        if (trig_wr) begin
          state_d = ST_RUN;
          cnt_d   = 4'h0;
          tx_d    = sr_q[7];
          ready_d = ~master;
        end
      end
      ST_RUN: begin
        if (master && tick)
          sclk_d = ~sclk_q;
        if (rise_ev) begin
          tx_d = sr_q[7];
          if (edge_q)
            sr_d = {sr_q[6:0], u_if_rx.level};
        end
        if (fall_ev) begin
          if (!edge_q)
            sr_d = {sr_q[6:0], u_if_rx.level};
          cnt_d = cnt_q + 4'h1;
          if (done) begin
            state_d = ST_IDLE;
            sclk_d  = 1'b0;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (master || rise_ev || data_acc)
      ready_d = 1'b0;
  end

  // ----------------------------------------
  // Control registers and interrupt
  // ----------------------------------------
  always_comb begin
    src_d   = src_q;
    edge_d  = edge_q;
    func_d  = func_q;
    outen_d = outen_q;
    gout_d  = gout_q;
    gdir_d  = gdir_q;
    irqen_d = irqen_q;
    if (wr && i_paddr == `SIO_OFF_CTRL) begin
      src_d   = i_pwdata[`SIO_CTRL_SRC_HI:`SIO_CTRL_SRC_LO];
      edge_d  = i_pwdata[`SIO_CTRL_EDGE];
      func_d  = i_pwdata[`SIO_CTRL_FUNC];
      outen_d = i_pwdata[`SIO_CTRL_OUTEN];
    end
    if (wr && i_paddr == `SIO_OFF_GPIO) begin
      gout_d = i_pwdata[3:0];
      gdir_d = i_pwdata[7:4];
    end
    if (wr && i_paddr == `SIO_OFF_IRQEN)
      irqen_d = i_pwdata[0];
    // A completion in the clear cycle survives
    flag_d = (flag_q & ~clr_wr) | done;
    irq_d  = flag_d & irqen_d;
  end

  // ----------------------------------------
  // Shared pin muxing
  // ----------------------------------------
  always_comb begin
    pout_d = gout_q;
    poe_d  = gdir_q;
    if (func_q)
      poe_d[0] = 1'b0;
    if (outen_q) begin
      pout_d[1] = tx_q;
      poe_d[1]  = 1'b1;
    end
    if (func_q && master) begin
      pout_d[2] = sclk_d ^ INV;
      poe_d[2]  = 1'b1;
    end else if (func_q) begin
      poe_d[2] = 1'b0;
    end
    if (func_q && !master) begin
      pout_d[3] = ready_d ^ INV;
      poe_d[3]  = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q   <= ST_IDLE;
      src_q     <= `SIO_SRC_RESET;
      edge_q    <= 1'b0;
      func_q    <= 1'b0;
      outen_q   <= 1'b0;
      gout_q    <= 4'h0;
      gdir_q    <= 4'h0;
      irqen_q   <= 1'b0;
      flag_q    <= 1'b0;
      sr_q      <= 8'h0;
      tx_q      <= 1'b0;
      sclk_q    <= 1'b0;
      cnt_q     <= 4'h0;
      ready_q   <= 1'b0;
      gap_q     <= 8'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
      pout_q    <= 4'h0;
      poe_q     <= 4'h0;
      irq_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      src_q     <= src_d;
      edge_q    <= edge_d;
      func_q    <= func_d;
      outen_q   <= outen_d;
      gout_q    <= gout_d;
      gdir_q    <= gdir_d;
      irqen_q   <= irqen_d;
      flag_q    <= flag_d;
      sr_q      <= sr_d;
      tx_q      <= tx_d;
      sclk_q    <= sclk_d;
      cnt_q     <= cnt_d;
      ready_q   <= ready_d;
      gap_q     <= gap_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      pout_q    <= pout_d;
      poe_q     <= poe_d;
      irq_q     <= irq_d;
    end
  end

  assign o_prdata   = prdata_q;
  assign o_pready   = pready_q;
  assign o_pslverr  = pslverr_q;
  assign o_port_out = pout_q;
  assign o_port_oe  = poe_q;
  assign o_irq      = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_trig_idle;
    trig_wr && state_q == ST_IDLE;
  endsequence
  sequence s_last_fall;
    fall_ev && cnt_q == `SIO_LAST_BIT;
  endsequence

  a_trigger_starts: assert property (
    s_trig_idle |=> state_q == ST_RUN && cnt_q == 4'h0)
    else $error("trigger did not start a transfer");
  a_byte_ends_idle: assert property (
    s_last_fall |=> state_q == ST_IDLE && !sclk_q && flag_q)
    else $error("transfer did not end after eight clocks");
  a_count_bound: assert property (
    cnt_q <= `SIO_BITS_PER_BYTE)
    else $error("bit count ran past eight");
  a_idle_no_clock: assert property (
    state_q == ST_IDLE |=> $stable(sclk_q))
    else $error("shift clock moved while idle");
  a_irq_gate: assert property (
    done |=> flag_q ##1 (o_irq == irqen_q))
    else $error("completion flag or interrupt wrong");
  a_ready_slave: assert property (
    ready_q |-> !master)
    else $error("ready raised in master mode");
  a_ready_drop: assert property (
    ready_q && (data_acc || ext_rise) |=> !ready_q)
    else $error("ready did not drop");
  a_timer_gap: assert property (
    $changed(sclk_q) && src_q == `SIO_SRC_TIMER && master
      |-> $past(gap_q) >= HALF_MIN)
    else $error("timer shift clock above limit");
  a_gpio_reset: assert property (
    !func_q && !outen_q |=> o_port_oe == $past(gdir_q))
    else $error("shared pins not general I/O");
endmodule : serial_port
`default_nettype wire

// ### sio_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-end serial device model
// ----------------------------------------
module sio_peer (
  input  wire logic i_clock,
  input  wire logic i_sclk,
  input  wire logic i_tx,
  output var  logic o_rx,
  output var  logic o_sclk
);
  logic [7:0] send_q;
  logic [7:0] got_q;

  // Idle clock low, as the pull-down would hold it
  initial begin
    o_rx = 1'b0;
    o_sclk = 1'b0;
    send_q = 8'h00;
    got_q = 8'h00;
  end

  // Capture tx on falling edge, since tx moves on rising
  always @(negedge i_sclk) begin
    got_q <= {got_q[6:0], i_tx};
    o_rx <= send_q[7];
    send_q <= {send_q[6:0], ~send_q[7]}; // Stale bits keep toggling
  end

  // First bit must stand before the first clock edge
  task automatic load(input logic [7:0] b);
    o_rx <= b[7];
    send_q <= {b[6:0], ~b[7]};
  endtask : load

  // Clock bursts; half period kept at 100 cycles or more
  task automatic clocks(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge i_clock);
      o_sclk <= 1'b1;
      repeat (half) @(posedge i_clock);
      o_sclk <= 1'b0;
    end
  endtask : clocks
endmodule : sio_peer
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sio_regs.svh"
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); \
  end \
end
module tb_top;
  localparam int OH = 110; // Oscillator half period, cycles
  localparam int TG = 110; // Underflow spacing, cycles
  logic        i_clock, i_rst_n, psel, penable, pwrite, osc, tmr, tgl;
  logic        err, sclk_l, e;
  logic [7:0]  paddr, rxb, txb;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, rx, psclk;
  wire  [3:0]  pout, poe;
  int          error_cnt, cmp_count, cyc, rises, last_rise, per;
  logic [1:0]  srcs [3];
  int          pers [3];
  // Resolved pin levels; undriven tx toggles so it never looks valid
  wire sclk_w = poe[2] ? pout[2] : psclk;
  wire tx_w   = poe[1] ? pout[1] : tgl;
  wire rdy_w  = poe[3] ? pout[3] : 1'b0;

  serial_port #(.POSITIVE_POL(1'b1)) serial_port_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_osc_clock(osc), .i_timer1_underflow(tmr),
    .i_port_in({rdy_w, sclk_w, tx_w, rx}), .o_port_out(pout),
    .o_port_oe(poe), .o_irq(irq));
  sio_peer sio_peer_i (.i_clock(i_clock), .i_sclk(sclk_w), .i_tx(tx_w),
    .o_rx(rx), .o_sclk(psclk));

  // ----------------------------------------
  // Clocks, sources and edge counting
  // ----------------------------------------
  // 200 MHz system clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  // Slow oscillator
  always begin
    repeat (OH) @(posedge i_clock);
    osc <= ~osc;
  end
  // One-cycle underflow pulses
  always begin
    repeat (TG - 1) @(posedge i_clock);
    tmr <= 1'b1;
    @(posedge i_clock);
    tmr <= 1'b0;
  end
  // Count shift clock rises and the last period
  always @(posedge i_clock) begin
    cyc++;
    tgl <= ~tgl;
    if (sclk_w && !sclk_l) begin
      rises++;
      per = cyc - last_rise;
      last_rise = cyc;
    end
    sclk_l = sclk_w;
  end

  // ----------------------------------------
  // Bus tasks and closing
  // ----------------------------------------
  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll the done flag; the watchdog bounds it
  task automatic wait_done();
    do apb(1'b0, `SIO_OFF_STATUS, 32'h0); while (rd[0] !== 1'b1);
  endtask : wait_done
  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Longest run is about 10k cycles
  initial begin
    repeat (60000) @(posedge i_clock);
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, osc, tmr, tgl, sclk_l, i_rst_n} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    srcs = '{`SIO_SRC_OSC, `SIO_SRC_OSC_HALF, `SIO_SRC_TIMER};
    pers = '{2 * OH, 4 * OH, 2 * TG};
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    `CHK(poe, 4'h0)
    apb(1'b0, `SIO_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b1, `SIO_OFF_GPIO, 32'h0);
    apb(1'b1, `SIO_OFF_CTRL, 32'h0B);
    repeat (4) @(posedge i_clock);
    `CHK(poe[1], 1'b0)
    // Every master source; osc half uses the opposite shift edge
    for (int i = 0; i < 3; i++) begin
      e = (i != 1);
      rxb = 8'h3C + 8'(i);
      txb = 8'hA5 ^ 8'(i);
      apb(1'b1, `SIO_OFF_CTRL, {27'h0, 2'b11, e, srcs[i]});
      sio_peer_i.load(rxb);
      apb(1'b1, `SIO_OFF_DATA, {24'h0, txb});
      rises = 0;
      apb(1'b1, `SIO_OFF_TRIG, 32'h1);
      wait_done();
      `CHK(rises, 8)
      `CHK(per, pers[i])
      repeat (400) @(posedge i_clock);
      `CHK(rises, 8)
      `CHK({sclk_w, poe[3:2]}, 3'b001)
      `CHK(irq, 1'b0)
      // Both shift edges must still deliver the whole byte each way
      apb(1'b0, `SIO_OFF_DATA, 32'h0);
      `CHK(rd[7:0], rxb)
      `CHK(sio_peer_i.got_q, txb)
      apb(1'b1, `SIO_OFF_CLEAR, 32'h1);
    end
    // Slave byte with a stray ninth clock
    apb(1'b1, `SIO_OFF_IRQEN, 32'h1);
    apb(1'b1, `SIO_OFF_CTRL, 32'h1C);
    sio_peer_i.load(8'h96);
    apb(1'b1, `SIO_OFF_DATA, 32'h5A);
    apb(1'b1, `SIO_OFF_TRIG, 32'h1);
    repeat (6) @(posedge i_clock);
    `CHK({rdy_w, poe[3:2]}, 3'b110)
    sio_peer_i.clocks(1, 110);
    `CHK(rdy_w, 1'b0)
    sio_peer_i.clocks(7, 110);
    repeat (12) @(posedge i_clock);
    `CHK(sio_peer_i.got_q, 8'h5A)
    `CHK(irq, 1'b1)
    sio_peer_i.clocks(1, 110);
    apb(1'b0, `SIO_OFF_DATA, 32'h0);
    `CHK(rd[7:0], 8'h96)
    apb(1'b1, `SIO_OFF_CLEAR, 32'h1);
    repeat (2) @(posedge i_clock);
    `CHK(irq, 1'b0)
    // Data access while armed drops ready
    apb(1'b1, `SIO_OFF_TRIG, 32'h1);
    repeat (6) @(posedge i_clock);
    `CHK(rdy_w, 1'b1)
    apb(1'b0, `SIO_OFF_DATA, 32'h0);
    repeat (6) @(posedge i_clock);
    `CHK(rdy_w, 1'b0)
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
